// >>> hw/bia_bus_master.sv
// Bus master sequencer for burst-inhibited and asynchronously acknowledged transfers.
`timescale 1ns/1ns

// Overview of operation
// - Burst disabled, not DRAM, and operand wider than port: split into single transfers.
// - Width code shows port size if operand wider and the transfer is burst-inhibited, else operand size.
// - Line code never shown in burst-inhibited mode; line operand shows port size.
// - DRAM operands wider than the port are always bursted, never inhibited.
// - Inhibited reads take two to sixteen transfers until the operand is read.
// - Inhibited writes take two to sixteen transfers until the operand is written.
// - Each inhibited follow-on transfer steps the address by port width and restarts; burst beats step without restarting.
// - First clock drives address, kind, code/data attribute, direction, width, start.
// - Second clock drops start strobe and shows supervisor or user.
// - Sample sync acknowledge from second clock on, waiting while it is low.
// - Write data driven from second clock, released after the last acknowledge.
// - Asynchronous acknowledge terminates anything except DRAM accesses.
// - Asynchronous acknowledge is synchronised before it may terminate.
// - Error acknowledge during synchronisation ends the transfer in error.
// - Async write data held until the synchronised acknowledge edge.
// - Codes: byte 01, word 10, longword 00, line 11.
// - Async acknowledge by mid second clock completes with one wait state.
module bia_bus_master (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic [bia_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic                        req_write,
  input  wire logic [1:0]                  req_kind,
  input  wire logic                        req_super,
  input  wire logic                        req_code,
  input  wire logic [1:0]                  req_op_size,
  input  wire logic [1:0]                  req_port_size,
  input  wire logic                        req_burst_en,
  input  wire logic                        req_dram,
  input  wire logic [bia_pkg::OP_W-1:0]    req_wdata,
  output logic                             resp_valid,
  output logic                             resp_error,
  output logic [bia_pkg::OP_W-1:0]         resp_rdata,
  output logic [bia_pkg::ADDR_W-1:0]       bus_addr,
  output logic [1:0]                       transfer_kind,
  output logic                             access_attr_mode,
  output logic                             read_write_dir,
  output logic [1:0]                       beat_width_code,
  output logic                             transfer_start_strobe,
  input  wire logic [bia_pkg::DATA_W-1:0]  data_in,
  output logic [bia_pkg::DATA_W-1:0]       data_out,
  output logic                             data_oe,
  input  wire logic                        sync_term_ack,
  input  wire logic                        async_term_ack,
  input  wire logic                        error_term_ack
);
  import bia_pkg::*;

  // ==========================================================================
  // Helper functions
  function automatic logic [2:0] size_log(input logic [1:0] code);
    unique case (code)
      SZ_BYTE: size_log = LOG_BYTE;
      SZ_WORD: size_log = LOG_WORD;
      SZ_LONG: size_log = LOG_LONG;
      SZ_LINE: size_log = LOG_LINE;
    endcase
  endfunction : size_log

  function automatic logic [1:0] log_code(input logic [2:0] lg);
    if (lg == LOG_BYTE) begin
      log_code = SZ_BYTE;
    end else if (lg == LOG_WORD) begin
      log_code = SZ_WORD;
    end else begin
      log_code = SZ_LONG;
    end
  endfunction : log_code

  // Next address: step by port bytes, wrapping inside the operand block.
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                   input logic [2:0] plog,
                                                   input logic [2:0] olog);
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] sum;
    mask      = (ADDR_W'(1) << olog) - ADDR_W'(1);
    sum       = a + (ADDR_W'(1) << plog);
    step_addr = (sum & mask) | (a & ~mask);
  endfunction : step_addr

  // Move write data up by one port width.
  function automatic logic [OP_W-1:0] shift_out(input logic [OP_W-1:0] w, input logic [2:0] plog);
    unique case (plog)
      LOG_BYTE: shift_out = {w[OP_W-9:0], 8'h00};
      LOG_WORD: shift_out = {w[OP_W-17:0], 16'h0000};
      default:  shift_out = {w[OP_W-33:0], DATA_RST};
    endcase
  endfunction : shift_out

  // Read data enters from the most significant lanes of the port.
  function automatic logic [OP_W-1:0] shift_in(input logic [OP_W-1:0] r, input logic [DATA_W-1:0] d,
                                                input logic [2:0] plog);
    unique case (plog)
      LOG_BYTE: shift_in = {r[OP_W-9:0], d[DATA_W-1:DATA_W-8]};
      LOG_WORD: shift_in = {r[OP_W-17:0], d[DATA_W-1:DATA_W-16]};
      default:  shift_in = {r[OP_W-33:0], d};
    endcase
  endfunction : shift_in

  // Replicate a narrow beat over all lanes so any lane placement finds it.
  function automatic logic [DATA_W-1:0] lanes(input logic [OP_W-1:0] w, input logic [2:0] blog);
    unique case (blog)
      LOG_BYTE: lanes = {4{w[OP_W-1:OP_W-8]}};
      LOG_WORD: lanes = {2{w[OP_W-1:OP_W-16]}};
      default:  lanes = w[OP_W-1:OP_W-32];
    endcase
  endfunction : lanes

  // ==========================================================================
  // State
  bia_state_e        state, next_state;
  logic [3:0]        beats_left, next_beats_left;
  logic [2:0]        plog, next_plog;
  logic [2:0]        olog, next_olog;
  logic [2:0]        blog, next_blog;
  logic              is_write, next_is_write;
  logic              sup, next_sup;
  logic              code, next_code;
  logic              burst, next_burst;
  logic              dram, next_dram;
  logic [OP_W-1:0]   wsh, next_wsh;
  logic [OP_W-1:0]   next_resp_rdata;
  logic              next_req_ready;
  logic              next_resp_valid;
  logic              next_resp_error;
  logic [ADDR_W-1:0] next_bus_addr;
  logic [1:0]        next_transfer_kind;
  logic              next_access_attr_mode;
  logic              next_read_write_dir;
  logic [1:0]        next_beat_width_code;
  logic              next_transfer_start_strobe;
  logic [DATA_W-1:0] next_data_out;
  logic              next_data_oe;
  logic              ata_int;
  logic              term_ok;
  logic              term_err;

  bia_ata_sync u_ata_sync (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .async_term_ack (async_term_ack),
    .ack_sync       (ata_int)
  );

  // The raw asynchronous input never reaches this logic, and DRAM ignores it.
  assign term_err = error_term_ack;
  assign term_ok  = sync_term_ack | (ata_int & ~dram);

  // ==========================================================================
  // Sequencer
  always_comb begin
    logic [2:0]      ol;
    logic [2:0]      pl;
    logic            multi;
    logic [OP_W-1:0] wn;
    ol = size_log(req_op_size);
    pl = size_log(req_port_size);
    multi = ol > pl;
    wn = shift_out(wsh, plog);
    next_state                 = state;
    next_beats_left            = beats_left;
    next_plog                  = plog;
    next_olog                  = olog;
    next_blog                  = blog;
    next_is_write              = is_write;
    next_sup                   = sup;
    next_code                  = code;
    next_burst                 = burst;
    next_dram                  = dram;
    next_wsh                   = wsh;
    next_resp_rdata            = resp_rdata;
    next_req_ready             = req_ready;
    next_resp_valid            = 1'b0;
    next_resp_error            = resp_error;
    next_bus_addr              = bus_addr;
    next_transfer_kind         = transfer_kind;
    next_access_attr_mode      = access_attr_mode;
    next_read_write_dir        = read_write_dir;
    next_beat_width_code       = beat_width_code;
    next_transfer_start_strobe = 1'b0;
    next_data_out              = data_out;
    next_data_oe               = data_oe;
    unique case (state)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          next_state                 = ST_START;
          next_req_ready             = 1'b0;
          next_resp_error            = 1'b0;
          next_resp_rdata            = OP_RST;
          next_plog                  = pl;
          next_olog                  = ol;
          next_blog                  = multi ? pl : ol;
          next_beats_left            = multi ? 4'((ONE_BEAT << (ol - pl)) - ONE_BEAT) : LAST_BEAT;
          next_burst                 = multi & (req_burst_en | req_dram);
          next_dram                  = req_dram;
          next_is_write              = req_write;
          next_sup                   = req_super;
          next_code                  = req_code;
          next_wsh                   = req_wdata;
          next_bus_addr              = req_addr;
          next_transfer_kind         = req_kind;
          next_access_attr_mode      = req_code;
          next_read_write_dir        = ~req_write;
          next_transfer_start_strobe = 1'b1;
          if (multi && !(req_burst_en || req_dram)) begin
            next_beat_width_code = log_code(pl);
          end else begin
            next_beat_width_code = req_op_size;
          end
        end
      end
      ST_START: begin
        next_state            = ST_WAIT;
        next_access_attr_mode = sup;
        next_data_oe          = is_write;
        next_data_out         = lanes(wsh, blog);
      end
      ST_WAIT: begin
        if (term_err) begin
          // Error wins over any acknowledge in the same clock.
          next_state      = ST_IDLE;
          next_resp_valid = 1'b1;
          next_resp_error = 1'b1;
          next_req_ready  = 1'b1;
          next_data_oe    = 1'b0;
        end else if (term_ok) begin
          if (!is_write) begin
            next_resp_rdata = shift_in(resp_rdata, data_in, plog);
          end
          if (beats_left == LAST_BEAT) begin
            next_state      = ST_IDLE;
            next_resp_valid = 1'b1;
            next_req_ready  = 1'b1;
            next_data_oe    = 1'b0;
          end else begin
            next_beats_left = beats_left - 4'h1;
            next_wsh        = wn;
            next_bus_addr   = step_addr(bus_addr, plog, olog);
            if (burst) begin
              next_data_out = lanes(wn, blog);
            end else begin
              next_state                 = ST_START;
              next_transfer_start_strobe = 1'b1;
              next_access_attr_mode      = code;
              next_data_oe               = 1'b0;
            end
          end
        end
        // Otherwise a wait state: everything holds, data included.
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state                 <= ST_IDLE;
      beats_left            <= LAST_BEAT;
      plog                  <= LOG_BYTE;
      olog                  <= LOG_BYTE;
      blog                  <= LOG_BYTE;
      is_write              <= 1'b0;
      sup                   <= 1'b0;
      code                  <= 1'b0;
      burst                 <= 1'b0;
      dram                  <= 1'b0;
      wsh                   <= OP_RST;
      resp_rdata            <= OP_RST;
      req_ready             <= 1'b1;
      resp_valid            <= 1'b0;
      resp_error            <= 1'b0;
      bus_addr              <= ADDR_RST;
      transfer_kind         <= 2'h0;
      access_attr_mode      <= 1'b0;
      read_write_dir        <= 1'b1;
      beat_width_code       <= SZ_LONG;
      transfer_start_strobe <= 1'b0;
      data_out              <= DATA_RST;
      data_oe               <= 1'b0;
    end else begin
      state                 <= next_state;
      beats_left            <= next_beats_left;
      plog                  <= next_plog;
      olog                  <= next_olog;
      blog                  <= next_blog;
      is_write              <= next_is_write;
      sup                   <= next_sup;
      code                  <= next_code;
      burst                 <= next_burst;
      dram                  <= next_dram;
      wsh                   <= next_wsh;
      resp_rdata            <= next_resp_rdata;
      req_ready             <= next_req_ready;
      resp_valid            <= next_resp_valid;
      resp_error            <= next_resp_error;
      bus_addr              <= next_bus_addr;
      transfer_kind         <= next_transfer_kind;
      access_attr_mode      <= next_access_attr_mode;
      read_write_dir        <= next_read_write_dir;
      beat_width_code       <= next_beat_width_code;
      transfer_start_strobe <= next_transfer_start_strobe;
      data_out              <= next_data_out;
      data_oe               <= next_data_oe;
    end
  end

  // ==========================================================================
  // Checks
  // Helper: counts start strobes of the running operation.
  logic [4:0] ts_cnt;
  logic [4:0] ts_total;
  always_ff @(posedge clk_sys) begin
    if (rst || state == ST_IDLE) begin
      ts_cnt <= 5'h00;
    end else if (transfer_start_strobe) begin
      ts_cnt <= ts_cnt + 5'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ts_total <= 5'h00;
    end else if (state == ST_START && transfer_start_strobe && ts_cnt == 5'h00) begin
      ts_total <= {1'b0, beats_left} + ONE_BEAT;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_strobe_one_clock: assert property (transfer_start_strobe |=> !transfer_start_strobe && access_attr_mode == sup)
    else $error("start strobe not dropped or wrong mode in second clock");
  a_no_line_inhib: assert property (state != ST_IDLE && !burst |-> beat_width_code != SZ_LINE)
    else $error("line code shown in burst-inhibited mode");
  a_dram_bursts: assert property (state != ST_IDLE && dram && olog > plog |-> burst)
    else $error("burst-inhibited transfer to DRAM");
  a_follow_on_hold: assert property (state == ST_WAIT && !term_err && term_ok && beats_left != LAST_BEAT && !burst
      |=> transfer_start_strobe && $stable(transfer_kind) && $stable(read_write_dir)
          && $stable(beat_width_code) && bus_addr != $past(bus_addr))
    else $error("follow-on transfer attributes wrong");
  a_wait_holds: assert property (state == ST_WAIT && !term_err && !term_ok
      |=> state == ST_WAIT && $stable(bus_addr) && $stable(data_out))
    else $error("transfer advanced without acknowledge");
  a_write_drive: assert property (state == ST_WAIT && is_write |-> data_oe)
    else $error("write data not driven while waiting");
  a_write_release: assert property (state == ST_WAIT && term_ok && beats_left == LAST_BEAT
      |=> !data_oe && resp_valid ##1 req_ready)
    else $error("data not released after last acknowledge");
  a_error_wins: assert property (state == ST_WAIT && error_term_ack |=> resp_valid && resp_error && state == ST_IDLE)
    else $error("error acknowledge did not end transfer in error");
  a_dram_no_async: assert property (state == ST_WAIT && dram && !sync_term_ack && !error_term_ack |=> state == ST_WAIT)
    else $error("DRAM access ended by asynchronous acknowledge");
  a_async_latency: assert property (async_term_ack ##1 async_term_ack |=> ata_int)
    else $error("synchronised acknowledge too late");
  a_beat_count: assert property (resp_valid && !resp_error && !burst && olog > plog
      |-> ts_cnt == ts_total && ts_total >= 5'(MIN_BEATS) && ts_total <= 5'(MAX_BEATS))
    else $error("wrong number of transfers in operation");

  c_inhib_line: cover property (state == ST_WAIT && !burst && olog == LOG_LINE && term_ok && beats_left == LAST_BEAT);
  c_async_write: cover property (state == ST_WAIT && is_write && ata_int && !sync_term_ack);
  c_error_end: cover property (resp_valid && resp_error);
  c_burst_op: cover property (state == ST_WAIT && burst && term_ok);
endmodule : bia_bus_master

// >>> hw/bia_pkg.sv
// Shared constants and types for the burst-inhibited bus master.
package bia_pkg;
  // ==========================================================================
  // Bus widths
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int OP_W   = 128;

  // ==========================================================================
  // Beat width codes, also used to encode operand and port sizes
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;

  // Size expressed as log2 of its byte count.
  localparam logic [2:0] LOG_BYTE = 3'h0;
  localparam logic [2:0] LOG_WORD = 3'h1;
  localparam logic [2:0] LOG_LONG = 3'h2;
  localparam logic [2:0] LOG_LINE = 3'h4;

  // Transfers per operation.
  localparam int         MIN_BEATS = 2;
  localparam int         MAX_BEATS = 16;
  localparam logic [3:0] LAST_BEAT = 4'h0;
  localparam logic [4:0] ONE_BEAT  = 5'h01;

  // ==========================================================================
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 28'h0000000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  localparam logic [OP_W-1:0]   OP_RST   = 128'h0;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT
  } bia_state_e;

  // Clock period of clk_sys.
  localparam int CLK_PERIOD_NS = 20;
endpackage : bia_pkg

// >>> hw/bia_ata_sync.sv
// Synchroniser for the asynchronous termination acknowledge.
`timescale 1ns/1ns
module bia_ata_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic async_term_ack,
  output logic      ack_sync
);
  import bia_pkg::*;

  logic stage1;

  // ==========================================================================
  // Two stages
  // The first stage samples on the falling edge so that an acknowledge
  // present by mid-cycle is usable at the following rising edge, which keeps
  // the documented one-wait-state turnaround.
  always_ff @(negedge clk_sys) begin
    if (rst) begin
      stage1 <= 1'b0;
    end else begin
      stage1 <= async_term_ack;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_sync <= 1'b0;
    end else begin
      ack_sync <= stage1;
    end
  end
endmodule : bia_ata_sync

// >>> test/bia_slave_model.sv
// Behavioural bus slave answering with sync, async or error acknowledges.
`timescale 1ns/1ns
module bia_slave_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        transfer_start_strobe,
  input  wire logic [27:0] bus_addr,
  input  wire logic [1:0]  waits,
  input  wire logic        use_async,
  input  wire logic        use_err,
  input  wire logic        keep_ack,
  output logic             sync_term_ack = 1'b0,
  output logic             async_term_ack = 1'b0,
  output logic             error_term_ack = 1'b0,
  output logic [31:0]      data_in = 32'h0
);
  int   cnt    = 0;
  int   held   = 0;
  logic active = 1'b0;

  // ==========================================================================
  // Responder
  // Released lines show the inverse of the last value so stale data never passes.
  always @(posedge clk_sys) begin
    #2;
    sync_term_ack = 1'b0;
    error_term_ack = 1'b0;
    if (held > 0) begin
      held--;
    end else begin
      // A region that must ignore the asynchronous acknowledge is finally answered synchronously here.
      sync_term_ack = async_term_ack && keep_ack;
      async_term_ack = 1'b0;
      data_in = ~data_in;
    end
    if (rst) begin
      active = 1'b0;
    end else if (transfer_start_strobe) begin
      active = 1'b1;
      cnt = waits;
    end else if (active) begin
      if (cnt > 0) begin
        cnt--;
      end else begin
        active = keep_ack && !use_async;
        data_in = {bus_addr[7:0] ^ 8'h5A, bus_addr[7:0], ~bus_addr[7:0], bus_addr[7:0] ^ 8'hC3};
        error_term_ack = use_err;
        sync_term_ack = !use_async && !use_err;
        if (use_async) begin
          async_term_ack = 1'b1;
          held = 1;
        end
      end
    end
  end
endmodule : bia_slave_model

// >>> test/burst_inhibited_async_ack_bus_test.sv
// Self-checking testbench of the burst-inhibited bus master.
`timescale 1ns/1ns
module burst_inhibited_async_ack_bus_test;
  import bia_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              req_valid = 1'b0, req_write = 1'b0, req_super = 1'b0, req_code = 1'b0;
  logic              req_burst_en = 1'b0, req_dram = 1'b0, use_async = 1'b0, use_err = 1'b0, keep_ack = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0, bus_addr;
  logic [1:0]        req_kind = 2'h0, req_op_size = 2'h0, req_port_size = 2'h0, waits = 2'h0, exp_bwc = 2'h0;
  logic [OP_W-1:0]   req_wdata = '0, resp_rdata;
  logic              req_ready, resp_valid, resp_error, access_attr_mode, read_write_dir, data_oe;
  logic              transfer_start_strobe, sync_term_ack, async_term_ack, error_term_ack;
  logic              burst = 1'b0, after_ts = 1'b0;
  logic [1:0]        transfer_kind, beat_width_code;
  logic [DATA_W-1:0] data_in, data_out;
  int                errors = 0, comparisons = 0, cycles = 0, beat = 0, nb = 1, w = 1, ob = 1, pb = 1;

  bia_bus_master i_bia_bus_master (.clk_sys, .rst, .req_valid, .req_ready, .req_addr, .req_write, .req_kind,
    .req_super, .req_code, .req_op_size, .req_port_size, .req_burst_en, .req_dram, .req_wdata, .resp_valid,
    .resp_error, .resp_rdata, .bus_addr, .transfer_kind, .access_attr_mode, .read_write_dir, .beat_width_code,
    .transfer_start_strobe, .data_in, .data_out, .data_oe, .sync_term_ack, .async_term_ack, .error_term_ack);
  bia_slave_model i_bia_slave_model (.clk_sys, .rst, .transfer_start_strobe, .bus_addr, .waits, .use_async,
    .use_err, .keep_ack, .sync_term_ack, .async_term_ack, .error_term_ack, .data_in);

  // ==========================================================================
  // Helpers
  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  function automatic int nbytes(logic [1:0] c);
    return (c == SZ_BYTE) ? 1 : (c == SZ_WORD) ? 2 : (c == SZ_LONG) ? 4 : 16;
  endfunction : nbytes

  // Write beats are taken from the top of the operand and replicated on all lanes.
  function automatic logic [31:0] wr_beat(int i);
    logic [127:0] c;
    c = req_wdata >> (128 - (i + 1) * w * 8);
    return (w == 1) ? {4{c[7:0]}} : (w == 2) ? {2{c[15:0]}} : c[31:0];
  endfunction : wr_beat

  function automatic logic [127:0] rd_exp();
    logic [127:0] r;
    logic [7:0]   a;
    logic [31:0]  d;
    r = '0;
    for (int i = 0; i < nb; i++) begin
      a = 8'(req_addr + 28'(i * w));
      d = {a ^ 8'h5A, a, ~a, a ^ 8'hC3};
      r = (r << (w * 8)) | 128'(d >> (32 - w * 8));
    end
    return r;
  endfunction : rd_exp

  // ==========================================================================
  // Clock, timeout and bus monitor
  initial begin
    forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  always @(posedge clk_sys) begin
    if (after_ts) begin
      check("start_low", transfer_start_strobe, 1'b0);
      check("attr_super", access_attr_mode, req_super);
    end
    after_ts = transfer_start_strobe;
    if (transfer_start_strobe) begin
      check("addr", bus_addr, 28'(req_addr + 28'(beat * w)));
      check("width", beat_width_code, exp_bwc);
      check("kind", transfer_kind, req_kind);
      check("dir", read_write_dir, !req_write);
      check("attr_code", access_attr_mode, req_code);
      beat++;
    end
    if (req_write && !burst && !use_err && beat > 0 && (sync_term_ack || async_term_ack)) begin
      check("wr_oe", data_oe, 1'b1);
      check("wr_data", data_out, wr_beat(beat - 1));
    end
  end

  // ==========================================================================
  // One operation from request to response
  task automatic run_op(input logic [1:0] op, port, input logic be, dram, wr, asy, input logic [1:0] wt,
                        input logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    #2;
    ob = nbytes(op);
    pb = nbytes(port);
    burst = (ob > pb) && (be || dram);
    nb = (ob > pb && !burst) ? ob / pb : 1;
    w = (ob > pb) ? pb : ob;
    exp_bwc = (ob > pb && !burst) ? port : op;
    {req_op_size, req_port_size, req_burst_en, req_dram, req_write} = {op, port, be, dram, wr};
    req_addr = 28'($urandom) & ~28'(ob - 1);
    req_wdata = {$urandom, $urandom, $urandom, $urandom};
    {req_kind, req_super, req_code} = 4'($urandom);
    {use_async, use_err, waits, keep_ack} = {asy, err, wt, burst || (asy && dram)};
    beat = 0;
    req_valid = 1'b1;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    #2;
    req_valid = 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (resp_valid !== 1'b1);
    check("error", resp_error, err);
    check("beats", beat, err ? 1 : nb);
    if (!err && !burst) check("cycles", n, nb * (2 + wt + asy) + 1 + (asy && dram));
    if (!wr && !err && !burst) check("rdata", resp_rdata, rd_exp());
    keep_ack = 1'b0;
    $display("op %0h port %0h write %0b async %0b done in %0d cycles", op, port, wr, asy, n);
  endtask : run_op

  // ==========================================================================
  // Main sequence: corner cases first, then random operations
  initial begin
    logic [1:0] op, port;
    logic       wr, be, dram, bst;
    void'($urandom(26));
    repeat (12) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    run_op(SZ_LINE, SZ_BYTE, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
    run_op(SZ_WORD, SZ_BYTE, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 1'b0);
    run_op(SZ_LONG, SZ_WORD, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0);
    run_op(SZ_LINE, SZ_LONG, 1'b0, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0);
    run_op(SZ_LONG, SZ_BYTE, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
    run_op(SZ_BYTE, SZ_LONG, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0, 1'b1);
    run_op(SZ_WORD, SZ_LONG, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0);
    run_op(SZ_BYTE, SZ_LONG, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0);
    for (int i = 0; i < 60; i++) begin
      op = 2'($urandom);
      port = 2'($urandom % 3);
      wr = 1'($urandom);
      if (!wr && nbytes(op) < nbytes(port)) op = port;
      dram = ($urandom % 8) == 0;
      be = ($urandom % 4) == 0;
      bst = (nbytes(op) > nbytes(port)) && (be || dram);
      run_op(op, port, be, dram, wr, !dram && !bst && 1'($urandom), 2'($urandom), !bst && ($urandom % 10) == 0);
    end
    results();
  end
endmodule : burst_inhibited_async_ack_bus_test
